// ===== rtl/gp0_port.sv
// Port-0 pin configuration block: AXI4-Lite registers, mode decode, six pins.
// Assumes peripherals enable their own functions; pads resolved outside.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "gp0_cfg.svh"
module gp0_port #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:2] port0_pin_in,
  output logic [7:2] port0_pin_out,
  output logic [7:2] port0_pin_oe,
  output logic [7:2] port0_pullup_en,
  output logic [5:0] analog_channel_sel,
  input wire logic timer2_output,
  input wire logic serial_unit_data_out,
  input wire logic serial_unit_clock_out,
  input wire logic timer1_pwm_output,
  input wire logic timer0_pwm_output,
  output logic ext_interrupt_5,
  output logic ext_interrupt_4,
  output logic ext_interrupt_3,
  output logic ext_interrupt_2,
  output logic ext_interrupt_1,
  output logic ext_interrupt_0,
  output logic counter2_clock_in,
  output logic counter1_clock_in,
  output logic counter0_clock_in,
  output logic serial_unit_data_in,
  output logic serial_unit_clock_in
);

  localparam int MIN_ADDR_W = 10;

  if (ADDR_W < MIN_ADDR_W) begin : g_addr_check
    $error("gp0_port: ADDR_W too small for register map");
  end

  logic [7:0] port0_pin_data;
  logic [7:0] port0_ctrl_high;
  logic [7:0] port0_ctrl_middle;
  logic [7:0] port0_ctrl_low;
  logic [7:0] port0_pullup_enable;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [7:0] wr_idx;
  logic wr_lane0;
  logic wr_hit;
  logic [7:0] rd_idx;
  logic [7:0] next_rdata;
  logic rd_hit;

  gp0_pkg::gp0_pin_mode_t pin_mode [7:2];
  logic [7:2] periph_drive;
  logic [7:2] pin_level;
  logic [7:2] out_mode;
  logic [7:2] in_mode;

  // Three-bit fields: 000 input, 001 open drain, 010 analog, 011 peripheral, 1xx push-pull
  function automatic gp0_pkg::gp0_pin_mode_t dec3(input logic [2:0] f);
    gp0_pkg::gp0_pin_mode_t m;
    m = gp0_pkg::gp0_pm_push_pull;
    case (f)
      3'h0: m = gp0_pkg::gp0_pm_input;
      3'h1: m = gp0_pkg::gp0_pm_open_drain;
      3'h2: m = gp0_pkg::gp0_pm_analog;
      3'h3: m = gp0_pkg::gp0_pm_periph;
      default: m = gp0_pkg::gp0_pm_push_pull;
    endcase
    return m;
  endfunction

  // Two-bit fields: last code is peripheral or push-pull per pin
  function automatic gp0_pkg::gp0_pin_mode_t dec2(input logic [1:0] f,
                                                  input logic last_periph);
    gp0_pkg::gp0_pin_mode_t m;
    m = gp0_pkg::gp0_pm_input;
    case (f)
      2'h0: m = gp0_pkg::gp0_pm_input;
      2'h1: m = gp0_pkg::gp0_pm_open_drain;
      2'h2: m = gp0_pkg::gp0_pm_analog;
      default: begin
        m = last_periph ? gp0_pkg::gp0_pm_periph : gp0_pkg::gp0_pm_push_pull;
      end
    endcase
    return m;
  endfunction

  always_comb begin
    // RULE2 pin7 decode
    pin_mode[7] = dec3(port0_ctrl_high[`GP0_PIN7_FIELD]);
    // RULE3 pin6 decode
    pin_mode[6] = dec3(port0_ctrl_high[`GP0_PIN6_FIELD]);
    // RULE4 pin5 override
    if (port0_ctrl_high[`GP0_PIN5_FORCE_PP]) begin
      pin_mode[5] = gp0_pkg::gp0_pm_push_pull;
    end else begin
      // RULE5 pin5 middle decode
      pin_mode[5] = dec2(port0_ctrl_middle[`GP0_PIN5_FIELD], 1'b1);
    end
    // RULE6 pin4 decode
    pin_mode[4] = dec3(port0_ctrl_middle[`GP0_PIN4_FIELD]);
    // RULE7 pin3 decode
    pin_mode[3] = dec3(port0_ctrl_middle[`GP0_PIN3_FIELD]);
    // RULE9 pin2 decode
    pin_mode[2] = dec2(port0_ctrl_low[`GP0_PIN2_FIELD], 1'b0);
  end

  // RULE11 peripheral drives pin
  always_comb begin
    periph_drive[7] = timer2_output;
    periph_drive[6] = serial_unit_data_out;
    periph_drive[5] = timer1_pwm_output;
    periph_drive[4] = serial_unit_clock_out;
    periph_drive[3] = timer0_pwm_output;
    // Pin 2 has no peripheral output
    periph_drive[2] = 1'b0;
  end

  for (genvar i = 2; i <= 7; i++) begin : g_pin
    assign out_mode[i] = (pin_mode[i] == gp0_pkg::gp0_pm_open_drain) ||
                         (pin_mode[i] == gp0_pkg::gp0_pm_push_pull);
    assign in_mode[i] = (pin_mode[i] == gp0_pkg::gp0_pm_input);

    gp0_pin_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .mode(pin_mode[i]),
      .data_bit(port0_pin_data[i]),
      .periph_out(periph_drive[i]),
      .pad_in(port0_pin_in[i]),
      .pad_out(port0_pin_out[i]),
      .pad_oe(port0_pin_oe[i]),
      .pin_level(pin_level[i]),
      .analog_sel(analog_channel_sel[i-2])
    );
  end

  // Peripheral inputs see the pin only while it is a Schmitt input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_interrupt_5 <= 1'b0;
      ext_interrupt_4 <= 1'b0;
      ext_interrupt_3 <= 1'b0;
      ext_interrupt_2 <= 1'b0;
      ext_interrupt_1 <= 1'b0;
      ext_interrupt_0 <= 1'b0;
    end else begin
      ext_interrupt_5 <= pin_level[7] & in_mode[7];
      ext_interrupt_4 <= pin_level[6] & in_mode[6];
      ext_interrupt_3 <= pin_level[5] & in_mode[5];
      ext_interrupt_2 <= pin_level[4] & in_mode[4];
      ext_interrupt_1 <= pin_level[3] & in_mode[3];
      ext_interrupt_0 <= pin_level[2] & in_mode[2];
    end
  end

  // Gated low otherwise, so a pin we drive cannot clock a counter
  // RULE12 serial clock input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter2_clock_in <= 1'b0;
      counter1_clock_in <= 1'b0;
      counter0_clock_in <= 1'b0;
      serial_unit_data_in <= 1'b0;
      serial_unit_clock_in <= 1'b0;
    end else begin
      counter2_clock_in <= pin_level[6] & in_mode[6];
      counter1_clock_in <= pin_level[4] & in_mode[4];
      counter0_clock_in <= pin_level[2] & in_mode[2];
      serial_unit_data_in <= pin_level[5] & in_mode[5];
      serial_unit_clock_in <= pin_level[4] & in_mode[4];
    end
  end

  // RULE13 pull-up outputs
  assign port0_pullup_en = port0_pullup_enable[7:2];

  // Write address and data are taken in either order and held
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx = aw_addr[9:2];
  // Registers are one byte wide, so only byte lane 0 counts
  assign wr_lane0 = w_strb[0];
  assign wr_hit = (wr_idx == `GP0_IDX_DATA) || (wr_idx == `GP0_IDX_CTRL_HIGH) ||
                  (wr_idx == `GP0_IDX_CTRL_MIDDLE) || (wr_idx == `GP0_IDX_CTRL_LOW) ||
                  (wr_idx == `GP0_IDX_PULLUP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // Unmapped index answers an error and writes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GP0_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `GP0_RESP_OKAY : `GP0_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // RULE15 masks drop unimplemented bits
  // RULE16 reserved bits ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // RULE1 high clears
      port0_ctrl_high <= `GP0_RST_CTRL_HIGH;
    end else if (wr_go && wr_lane0 && (wr_idx == `GP0_IDX_CTRL_HIGH)) begin
      port0_ctrl_high <= w_data[7:0] & `GP0_MASK_CTRL_HIGH;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // RULE8 middle clears
      port0_ctrl_middle <= `GP0_RST_CTRL_MIDDLE;
    end else if (wr_go && wr_lane0 && (wr_idx == `GP0_IDX_CTRL_MIDDLE)) begin
      port0_ctrl_middle <= w_data[7:0] & `GP0_MASK_CTRL_MIDDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // RULE10 low clears
      port0_ctrl_low <= `GP0_RST_CTRL_LOW;
    end else if (wr_go && wr_lane0 && (wr_idx == `GP0_IDX_CTRL_LOW)) begin
      port0_ctrl_low <= w_data[7:0] & `GP0_MASK_CTRL_LOW;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port0_pullup_enable <= `GP0_RST_PULLUP;
    end else if (wr_go && wr_lane0 && (wr_idx == `GP0_IDX_PULLUP)) begin
      // RULE13 pull-up write
      port0_pullup_enable <= w_data[7:0] & `GP0_MASK_PULLUP;
    end
  end

  // Latch written in any mode, so the level is ready before output is chosen
  // RULE14 output latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port0_pin_data <= `GP0_RST_DATA;
    end else if (wr_go && wr_lane0 && (wr_idx == `GP0_IDX_DATA)) begin
      port0_pin_data <= w_data[7:0] & `GP0_MASK_DATA;
    end
  end

  // Read side: one read at a time, answered from a register
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx = s_axi_araddr[9:2];

  always_comb begin
    next_rdata = 8'h00;
    rd_hit = 1'b1;
    case (rd_idx)
      `GP0_IDX_DATA: begin
        // RULE14 read pins or latch
        for (int i = 2; i <= 7; i++) begin
          next_rdata[i] = out_mode[i] ? port0_pin_data[i] : pin_level[i];
        end
      end
      `GP0_IDX_CTRL_HIGH: next_rdata = port0_ctrl_high;
      `GP0_IDX_CTRL_MIDDLE: next_rdata = port0_ctrl_middle;
      `GP0_IDX_CTRL_LOW: next_rdata = port0_ctrl_low;
      `GP0_IDX_PULLUP: next_rdata = port0_pullup_enable;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Answer kept in flops, so it stands while the master stalls rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GP0_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= {24'h00_0000, next_rdata};
      s_axi_rresp <= rd_hit ? `GP0_RESP_OKAY : `GP0_RESP_SLVERR;
    end
  end

endmodule // gp0_port

// ===== pkg/gp0_cfg.svh
// Register map, field positions and reset values of the port-0 pin block.
// Assumes a byte-addressed 32-bit AXI4-Lite bus; byte address is four times the index.
// Operation
// RULE1 - Reset clears high control register to zero
// RULE2 - Pin7 field decodes input/od/analog/timer2/pushpull
// RULE3 - Pin6 field decodes input/od/analog/serial-out/pushpull
// RULE4 - High bit0 forces pin5 push-pull, else middle
// RULE5 - Pin5 middle field decodes input/od/analog/timer1
// RULE6 - Pin4 field decodes input/od/analog/serial-clock/pushpull
// RULE7 - Pin3 field decodes input/od/analog/timer0/pushpull
// RULE8 - Reset clears middle control register to zero
// RULE9 - Pin2 field decodes input/od/analog/pushpull
// RULE10 - Reset clears low control register to zero
// RULE11 - Software also enables peripheral inside peripheral
// RULE12 - Serial slave needs serial clock pin input
// RULE13 - Pull-up bits 7..2 enable pin pull-ups
// RULE14 - Data bits read inputs, drive outputs
// RULE15 - Listed bit positions are unimplemented
// RULE16 - Unimplemented bits read zero, ignore writes
`ifndef GP0_CFG_SVH
`define GP0_CFG_SVH

`define GP0_IDX_DATA 8'hc0
`define GP0_IDX_CTRL_HIGH 8'hc6
`define GP0_IDX_CTRL_MIDDLE 8'hc7
`define GP0_IDX_CTRL_LOW 8'hc8
`define GP0_IDX_PULLUP 8'hc9

`define GP0_MASK_DATA 8'hfc
`define GP0_MASK_CTRL_HIGH 8'hfd
`define GP0_MASK_CTRL_MIDDLE 8'hff
`define GP0_MASK_CTRL_LOW 8'h30
`define GP0_MASK_PULLUP 8'hfc

`define GP0_RST_DATA 8'h00
`define GP0_RST_CTRL_HIGH 8'h00
`define GP0_RST_CTRL_MIDDLE 8'h00
`define GP0_RST_CTRL_LOW 8'h00
`define GP0_RST_PULLUP 8'h00

`define GP0_PIN7_FIELD 7:5
`define GP0_PIN6_FIELD 4:2
`define GP0_PIN5_FORCE_PP 0
`define GP0_PIN5_FIELD 7:6
`define GP0_PIN4_FIELD 5:3
`define GP0_PIN3_FIELD 2:0
`define GP0_PIN2_FIELD 5:4

`define GP0_RESP_OKAY 2'h0
`define GP0_RESP_SLVERR 2'h2

`endif

// ===== pkg/gp0_pkg.sv
// Types shared by the port-0 pin block.
// Assumes nothing of its surroundings.
package gp0_pkg;

  typedef enum logic [2:0] {
    gp0_pm_input,
    gp0_pm_open_drain,
    gp0_pm_push_pull,
    gp0_pm_analog,
    gp0_pm_periph
  } gp0_pin_mode_t;

endpackage

// ===== rtl/gp0_pin_cell.sv
// One port pin: input synchroniser and registered pad drive for a given mode.
// Assumes the pad is resolved outside from pad_out and pad_oe.
`timescale 1ns/1ps
module gp0_pin_cell (
  input wire logic aclk,
  input wire logic aresetn,
  input wire gp0_pkg::gp0_pin_mode_t mode,
  input wire logic data_bit,
  input wire logic periph_out,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pin_level,
  output logic analog_sel
);

  logic sync1;
  logic sync2;
  logic sync3;

  // Pin is asynchronous; level accepted only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        pin_level <= sync3;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      analog_sel <= 1'b0;
    end else begin
      analog_sel <= (mode == gp0_pkg::gp0_pm_analog);
      case (mode)
        gp0_pkg::gp0_pm_open_drain: begin
          // Only pulls low; high level comes from pull-up or outside
          pad_out <= 1'b0;
          pad_oe <= ~data_bit;
        end
        gp0_pkg::gp0_pm_push_pull: begin
          pad_out <= data_bit;
          pad_oe <= 1'b1;
        end
        gp0_pkg::gp0_pm_periph: begin
          pad_out <= periph_out;
          pad_oe <= 1'b1;
        end
        default: begin
          pad_out <= 1'b0;
          pad_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule // gp0_pin_cell

// ===== verif/gp0_port_assertions.sv
// Bus and pin-mode checks for the port-0 pin block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module gp0_port_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:2] port0_pin_oe,
  input wire logic [5:0] analog_channel_sel,
  input wire logic ext_interrupt_5,
  input wire logic serial_unit_clock_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper bits set");
  write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid && !s_axi_awready) else $error("write late");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
  analog_undriven_a: assert property (
    (analog_channel_sel & port0_pin_oe) == 6'h00) else $error("analog pin driven");
  input_undriven_a: assert property (
    ext_interrupt_5 |-> !port0_pin_oe[7] && !analog_channel_sel[5])
    else $error("input pin driven");
  sclk_input_a: assert property (
    serial_unit_clock_in |-> !port0_pin_oe[4]) else $error("clock pin driven");
  reset_quiet_a: assert property (
    $rose(aresetn) |-> port0_pin_oe == 6'h00 && analog_channel_sel == 6'h00)
    else $error("pins active after reset");
endmodule // gp0_port_assertions

// ===== verif/gp0_pad_model.sv
// Pad model: external drivers, pull-ups and floating pins of port 0.
// Assumes the bench sets one external driver per pin.
`timescale 1ns/1ps
module gp0_pad_model (
  input wire logic aclk,
  input wire logic [7:2] pin_out,
  input wire logic [7:2] pin_oe,
  input wire logic [7:2] pullup_en,
  input wire logic [7:2] ext_en,
  input wire logic [7:2] ext_val,
  output logic [7:2] pin_in
);
  logic [7:2] last;
  always_ff @(posedge aclk) begin
    last <= pin_in;
  end
  // drive, then pull-up
  // Unpulled released pin wanders, never holds
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pullup_en | ~last));
endmodule // gp0_pad_model

// ===== verif/test_gp0_port.sv
// Self-checking bench for the port-0 pin block.
// Assumes the pad model closes the pin loop.
`timescale 1ns/1ps
`include "gp0_cfg.svh"
module test_gp0_port;
  localparam logic [11:0] A_DT = {2'b00, `GP0_IDX_DATA, 2'b00};
  localparam logic [11:0] A_HI = {2'b00, `GP0_IDX_CTRL_HIGH, 2'b00};
  localparam logic [11:0] A_MD = {2'b00, `GP0_IDX_CTRL_MIDDLE, 2'b00};
  localparam logic [11:0] A_LO = {2'b00, `GP0_IDX_CTRL_LOW, 2'b00};
  localparam logic [11:0] A_PU = {2'b00, `GP0_IDX_PULLUP, 2'b00};
  localparam logic [1:0] OK = `GP0_RESP_OKAY;
  localparam logic [1:0] ER = `GP0_RESP_SLVERR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:2] port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup_en, ext_en, ext_val;
  logic [5:0] analog_channel_sel, ext;
  logic timer2_output, serial_unit_data_out, serial_unit_clock_out;
  logic timer1_pwm_output, timer0_pwm_output, ext_interrupt_5, ext_interrupt_4;
  logic ext_interrupt_3, ext_interrupt_2, ext_interrupt_1, ext_interrupt_0;
  logic counter2_clock_in, counter1_clock_in, counter0_clock_in;
  logic serial_unit_data_in, serial_unit_clock_in;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  assign ext = {ext_interrupt_5, ext_interrupt_4, ext_interrupt_3, ext_interrupt_2,
    ext_interrupt_1, ext_interrupt_0};
  assign s_axi_awprot = cyc[2:0];
  assign s_axi_arprot = cyc[3:1];
  gp0_port u_gp0_port (.*);
  gp0_pad_model u_gp0_pad_model (.aclk(aclk), .pin_out(port0_pin_out),
    .pin_oe(port0_pin_oe), .pullup_en(port0_pullup_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(port0_pin_in));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      $display("wrong value at %0t: timeout", $time);
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_val(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_resp(logic [1:0] g, logic [1:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: response %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d, logic [3:0] s, logic [1:0] r);
    bit done, ha, hw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 0;
    while (!done) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid === 1'b1) begin
        cmp_resp(s_axi_bresp, r);
        done = 1;
      end
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] r);
    bit done, ha;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 0;
    while (!done) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid === 1'b1) begin
        cmp_val(s_axi_rdata, e);
        cmp_resp(s_axi_rresp, r);
        done = 1;
      end
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
  endtask
  // Pin view: drive, driven level, analog select, input path
  function automatic logic [3:0] obs(int p);
    return {port0_pin_oe[p], port0_pin_oe[p] & port0_pin_out[p],
      analog_channel_sel[p-2], ext[p-2]};
  endfunction
  function automatic logic [3:0] ex(int c, int nc, logic [3:0] top);
    if (c == 3) return (nc == 4) ? top : 4'h8;
    if (c > 3) return 4'hc;
    return (c == 0) ? 4'h1 : (c == 1) ? 4'h0 : 4'h2;
  endfunction
  task automatic sweep(logic [11:0] a, int p, int sh, int nc, logic [3:0] top);
    for (int c = 0; c < nc; c++) begin
      wr(a, 8'(c << sh), 4'h1, OK);
      repeat (8) @(posedge aclk);
      cmp_val(32'(obs(p)), 32'(ex(c, nc, top)));
    end
  endtask
  task automatic t_reset;
    rd(A_DT, 32'h0, OK);
    rd(A_HI, 32'h0, OK);
    rd(A_MD, 32'h0, OK);
    rd(A_LO, 32'h0, OK);
    rd(A_PU, 32'h0, OK);
    cmp_val(32'({port0_pin_oe, analog_channel_sel}), 32'h0);
    $display("reset test done");
  endtask
  task automatic t_masks;
    logic [11:0] a[4];
    logic [7:0] m[4];
    a = '{A_HI, A_MD, A_LO, A_PU};
    m = '{8'hfd, 8'hff, 8'h30, 8'hfc};
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 8'hff, 4'h1, OK);
      rd(a[i], 32'(m[i]), OK);
    end
    cmp_val(32'(port0_pullup_en), 32'h3f);
    wr(A_DT, 8'hff, 4'h1, OK);
    rd(A_DT, 32'hfc, OK);
    cmp_val(32'({port0_pin_oe, port0_pin_out}), 32'hfff);
    for (int i = 0; i < 4; i++) wr(a[i], 8'h00, 4'h1, OK);
    $display("mask test done");
  endtask
  task automatic t_bad;
    wr(A_DT + 12'h4, 8'hff, 4'h1, ER);
    rd(A_DT + 12'h4, 32'h0, ER);
    wr(A_HI, 8'hff, 4'h0, OK);
    rd(A_HI, 32'h0, OK);
    $display("refusal test done");
  endtask
  task automatic t_modes;
    wr(A_DT, 8'hfc, 4'h1, OK);
    ext_val <= 6'h3f;
    sweep(A_HI, 7, 5, 8, 4'h8);
    sweep(A_HI, 6, 2, 8, 4'h8);
    sweep(A_MD, 5, 6, 4, 4'h8);
    sweep(A_MD, 4, 3, 8, 4'h8);
    sweep(A_MD, 3, 0, 8, 4'h8);
    sweep(A_LO, 2, 4, 4, 4'hc);
    wr(A_MD, 8'h80, 4'h1, OK);
    wr(A_HI, 8'h01, 4'h1, OK);
    repeat (8) @(posedge aclk);
    cmp_val(32'(obs(5)), 32'hc);
    // Each peripheral output on its own pin, alternating levels
    {timer2_output, serial_unit_data_out, timer1_pwm_output} <= 3'h5;
    {serial_unit_clock_out, timer0_pwm_output} <= 2'h1;
    wr(A_HI, 8'h6c, 4'h1, OK);
    wr(A_MD, 8'hdb, 4'h1, OK);
    repeat (4) @(posedge aclk);
    cmp_val(32'({port0_pin_oe[7:3], port0_pin_out[7:3]}), 32'h3f5);
    {timer2_output, serial_unit_data_out, timer1_pwm_output} <= 3'h0;
    {serial_unit_clock_out, timer0_pwm_output} <= 2'h0;
    $display("mode test done");
  endtask
  task automatic t_levels;
    wr(A_HI, 8'h00, 4'h1, OK);
    wr(A_MD, 8'h00, 4'h1, OK);
    wr(A_LO, 8'h00, 4'h1, OK);
    ext_val <= 6'h29;
    repeat (8) @(posedge aclk);
    rd(A_DT, 32'ha4, OK);
    cmp_val(32'({ext, counter2_clock_in, counter1_clock_in, counter0_clock_in,
      serial_unit_data_in, serial_unit_clock_in}), 32'h526);
    ext_en <= 6'h00;
    wr(A_PU, 8'hfc, 4'h1, OK);
    repeat (8) @(posedge aclk);
    rd(A_DT, 32'hfc, OK);
    cmp_val(32'({ext, counter2_clock_in, counter1_clock_in, counter0_clock_in,
      serial_unit_data_in, serial_unit_clock_in}), 32'h7ff);
    ext_en <= 6'h3f;
    wr(A_PU, 8'h00, 4'h1, OK);
    $display("level test done");
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    ext_en = 6'h3f;
    ext_val = 6'h00;
    // Peripherals idle low so their pin use stands apart from push-pull
    {timer2_output, serial_unit_data_out, serial_unit_clock_out} = 3'h0;
    {timer1_pwm_output, timer0_pwm_output} = 2'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_masks;
    t_bad;
    t_modes;
    t_levels;
    wrap_up;
  end
endmodule // test_gp0_port
bind gp0_port gp0_port_assertions u_gp0_port_assertions (.*);
